// ===== osw_pkg.sv
`default_nettype none

package osw_pkg;

  // ----------------------------------------------------------------------
  // Register map (byte addresses on the plain register port)
  // ----------------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam logic [7:0] ADDR_CTRL_ONE = 8'h00;
  localparam logic [7:0] ADDR_CTRL_THREE = 8'h04;
  localparam logic [7:0] ADDR_CONFIG = 8'h08;
  localparam logic [7:0] ADDR_MODE = 8'h0C;
  localparam logic [7:0] ADDR_STATUS = 8'h10;
  localparam logic [7:0] ADDR_REMAIN = 8'h14;

  // ----------------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------------
  localparam int CTRL_ONE_SEL_LSB = 0;
  localparam int CTRL_THREE_SEL_BIT = 0;
  localparam int CFG_VARIANT_LSB = 0;
  localparam int CFG_EXT_CLK_BIT = 2;
  localparam int MODE_SLEEP_BIT = 0;
  localparam int MODE_ACTIVE_BIT = 1;
  localparam int MODE_SUB_TARGET_BIT = 2;
  localparam int STAT_STATE_LSB = 0;
  localparam int STAT_SYSCLK_BIT = 2;
  localparam int STAT_OSC_BIT = 3;
  localparam int STAT_EXT_CODE_BIT = 4;
  localparam int STAT_MISMATCH_BIT = 5;

  // ----------------------------------------------------------------------
  // Wait counter width and cycle counts
  // ----------------------------------------------------------------------
  localparam int CNT_W = 18;
  localparam logic [17:0] CYC_2 = 18'h00002;
  localparam logic [17:0] CYC_4 = 18'h00004;
  localparam logic [17:0] CYC_8 = 18'h00008;
  localparam logic [17:0] CYC_16 = 18'h00010;
  localparam logic [17:0] CYC_32 = 18'h00020;
  localparam logic [17:0] CYC_128 = 18'h00080;
  localparam logic [17:0] CYC_256 = 18'h00100;
  localparam logic [17:0] CYC_512 = 18'h00200;
  localparam logic [17:0] CYC_1024 = 18'h00400;
  localparam logic [17:0] CYC_2048 = 18'h00800;
  localparam logic [17:0] CYC_4096 = 18'h01000;
  localparam logic [17:0] CYC_8192 = 18'h02000;
  localparam logic [17:0] CYC_16384 = 18'h04000;
  localparam logic [17:0] CYC_32768 = 18'h08000;
  localparam logic [17:0] CYC_65536 = 18'h10000;
  localparam logic [17:0] CYC_131072 = 18'h20000;
  localparam logic [17:0] CNT_LAST = 18'h00001;
  localparam logic [17:0] CNT_ZERO = 18'h00000;

  // ----------------------------------------------------------------------
  // Codes, states, variants
  // ----------------------------------------------------------------------
  localparam logic [2:0] EXT_CODE_3BIT = 3'h5;
  localparam logic [3:0] EXT_CODE_4BIT = 4'h5;

  typedef enum logic [1:0] {
    VAR_FIRST3 = 2'b00,
    VAR_SECOND3 = 2'b01,
    VAR_FOUR = 2'b10
  } osw_variant_type;

  typedef enum logic [1:0] {
    ST_ACTIVE = 2'b00,
    ST_HALT = 2'b01,
    ST_SUB = 2'b10,
    ST_WAIT = 2'b11
  } osw_state_type;

  typedef struct packed {
    logic wait_sel_bit3;
    logic wait_sel_bit2;
    logic wait_sel_bit1;
    logic wait_sel_bit0;
  } osw_sel_type;

  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } osw_bus_type;

  // Reset values
  localparam osw_sel_type RST_SEL = 4'h0;
  localparam osw_variant_type RST_VARIANT = VAR_FOUR;

endpackage : osw_pkg

`default_nettype wire

// ===== osw_wait_lookup.sv
`default_nettype none

module osw_wait_lookup (
  // Selection
  input wire osw_pkg::osw_variant_type variant,
  input wire osw_pkg::osw_sel_type sel,
  // Result
  output logic [17:0] cycles,
  output logic ext_code
);

  // ----------------------------------------------------------------------
  // Code to cycle count, per product variant
  // ----------------------------------------------------------------------
  function automatic logic [17:0] osw_decode(
    input osw_pkg::osw_variant_type v,
    input logic [3:0] c
  );
    logic [17:0] r;
    r = osw_pkg::CYC_8192;
    case (v)
      osw_pkg::VAR_FIRST3: begin // [R4]
        case (c[2:0])
          3'h0: r = osw_pkg::CYC_8192;
          3'h1: r = osw_pkg::CYC_16384;
          3'h2: r = osw_pkg::CYC_32768;
          3'h3: r = osw_pkg::CYC_65536;
          3'h4: r = osw_pkg::CYC_131072;
          3'h5: r = osw_pkg::CYC_2;
          3'h6: r = osw_pkg::CYC_8;
          default: r = osw_pkg::CYC_16;
        endcase
      end
      osw_pkg::VAR_SECOND3: begin // [R5]
        case (c[2:0])
          3'h0: r = osw_pkg::CYC_8192;
          3'h1: r = osw_pkg::CYC_16384;
          3'h2: r = osw_pkg::CYC_1024;
          3'h3: r = osw_pkg::CYC_2048;
          3'h4: r = osw_pkg::CYC_4096;
          3'h5: r = osw_pkg::CYC_256;
          3'h6: r = osw_pkg::CYC_512;
          default: r = osw_pkg::CYC_16;
        endcase
      end
      osw_pkg::VAR_FOUR: begin
        case (c)
          4'h0: r = osw_pkg::CYC_8192; // [R6]
          4'h1: r = osw_pkg::CYC_16384; // [R6]
          4'h2: r = osw_pkg::CYC_1024; // [R6]
          4'h3: r = osw_pkg::CYC_2048; // [R6]
          4'h4: r = osw_pkg::CYC_4096; // [R6]
          4'h5: r = osw_pkg::CYC_2; // [R6]
          4'h6: r = osw_pkg::CYC_8; // [R6]
          4'h7: r = osw_pkg::CYC_16; // [R6]
          4'h8: r = osw_pkg::CYC_256; // [R7]
          4'h9: r = osw_pkg::CYC_512; // [R7]
          4'hA: r = osw_pkg::CYC_32768; // [R7]
          4'hB: r = osw_pkg::CYC_65536; // [R7]
          4'hC: r = osw_pkg::CYC_131072; // [R7]
          4'hD: r = osw_pkg::CYC_4; // [R7]
          4'hE: r = osw_pkg::CYC_32; // [R7]
          default: r = osw_pkg::CYC_128; // [R7]
        endcase
      end
      // Unused variant code falls back to the 8,192-cycle default
      default: r = osw_pkg::CYC_8192;
    endcase
    return r;
  endfunction : osw_decode

  // Count and external-clock code flag
  always_comb begin
    cycles = osw_decode(variant, sel);
    if (variant == osw_pkg::VAR_FOUR) begin
      ext_code = (sel == osw_pkg::EXT_CODE_4BIT);
    end else if (variant == osw_pkg::VAR_FIRST3) begin
      ext_code = (sel[2:0] == osw_pkg::EXT_CODE_3BIT);
    end else begin
      ext_code = 1'b0; // Second 3-bit variant has no external code
    end
  end

endmodule : osw_wait_lookup

`default_nettype wire

// ===== osw_wait_counter.sv
`default_nettype none

module osw_wait_counter (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Control
  input wire logic load,
  input wire logic [17:0] load_value,
  input wire logic run,
  // Status
  output logic [17:0] remain,
  output logic last
);

  // ----------------------------------------------------------------------
  // Down counter clocked by the raw oscillator
  // ----------------------------------------------------------------------
  always_ff @(posedge clk) begin // [R11]
    if (!resetn) begin
      remain <= osw_pkg::CNT_ZERO;
    end else if (load) begin
      remain <= load_value;
    end else if (run && remain != osw_pkg::CNT_ZERO) begin
      remain <= remain - osw_pkg::CNT_LAST;
    end
  end

  // Final counted cycle
  assign last = run && (remain == osw_pkg::CNT_LAST);

endmodule : osw_wait_counter

`default_nettype wire

// ===== osw_wait_ctrl.sv
// Summary of operation
// R1: Wake into active mode starts stabilization wait
// R2: Count selected cycles, then supply system clock
// R3: Software picks wait at least oscillator stabilization
// R4: First 3-bit variant code to cycle table
// R5: Second 3-bit variant code to cycle table
// R6: 4-bit variant, top clear, cycle table
// R7: 4-bit variant, top set, cycle table
// R8: External clock: set code before transition
// R9: Never external code with a resonator
// R10: On-chip oscillator, first variant: 8,192 recommended
// R11: Counter runs on oscillator clock cycles
`default_nettype none

module osw_wait_ctrl (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Register port
  input wire osw_pkg::osw_bus_type bus,
  output logic [31:0] rdata,
  // Wake event from the interrupt logic
  input wire logic wake_pin,
  // Clock control
  output logic osc_run,
  output logic sysclk_en,
  output osw_pkg::osw_state_type mode_state
);

  // ----------------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------------
  // Configuration held for software, mode state and mode requests
  osw_pkg::osw_sel_type sel;
  osw_pkg::osw_variant_type variant;
  osw_pkg::osw_state_type state;
  osw_pkg::osw_state_type next_state;
  logic ext_clk;
  logic sub_target;
  logic sleep_req;
  logic active_req;
  // Wake synchroniser and edge detector
  logic wake_s1;
  logic wake_s2;
  logic wake_s3;
  logic wake_level;
  logic wake_rise;
  // Lookup and counter links
  logic [17:0] wait_cycles;
  logic ext_code;
  logic code_mismatch;
  logic cnt_load;
  logic cnt_run;
  logic [17:0] cnt_remain;
  logic cnt_last;
  // Decoded write strobes
  logic wr_ctrl_one;
  logic wr_ctrl_three;
  logic wr_config;
  logic wr_mode;

  // ----------------------------------------------------------------------
  // Register write decode
  // ----------------------------------------------------------------------
  // Write strobe for one mapped address; every register decodes the
  // same way, so the compare lives in one place
  function automatic logic write_hit(
    input osw_pkg::osw_bus_type b,
    input logic [7:0] a
  );
    return b.wr && (b.addr == a);
  endfunction : write_hit

  // One strobe per writable address; unmapped writes fall through unused
  assign wr_ctrl_one = write_hit(bus, osw_pkg::ADDR_CTRL_ONE);
  assign wr_ctrl_three = write_hit(bus, osw_pkg::ADDR_CTRL_THREE);
  assign wr_config = write_hit(bus, osw_pkg::ADDR_CONFIG);
  assign wr_mode = write_hit(bus, osw_pkg::ADDR_MODE);

  // Wait-select low three bits in the first control register
  always_ff @(posedge clk) begin
    if (!resetn) begin
      sel.wait_sel_bit2 <= osw_pkg::RST_SEL.wait_sel_bit2;
      sel.wait_sel_bit1 <= osw_pkg::RST_SEL.wait_sel_bit1;
      sel.wait_sel_bit0 <= osw_pkg::RST_SEL.wait_sel_bit0;
    end else if (wr_ctrl_one) begin
      sel.wait_sel_bit2 <= bus.wdata[osw_pkg::CTRL_ONE_SEL_LSB + 2];
      sel.wait_sel_bit1 <= bus.wdata[osw_pkg::CTRL_ONE_SEL_LSB + 1];
      sel.wait_sel_bit0 <= bus.wdata[osw_pkg::CTRL_ONE_SEL_LSB];
    end
  end

  // Top wait-select bit lives in the third control register
  // Each part of the select (low three bits, top bit) has its own strobe and process
  always_ff @(posedge clk) begin
    if (!resetn) begin
      sel.wait_sel_bit3 <= osw_pkg::RST_SEL.wait_sel_bit3;
    end else if (wr_ctrl_three) begin
      sel.wait_sel_bit3 <= bus.wdata[osw_pkg::CTRL_THREE_SEL_BIT];
    end
  end

  // Variant and clock source configuration
  // A variant code of 3 names no product group; the lookup then
  // falls back to the 8,192-cycle default
  always_ff @(posedge clk) begin
    if (!resetn) begin
      variant <= osw_pkg::RST_VARIANT;
      ext_clk <= 1'b0;
    end else if (wr_config) begin
      variant <= osw_pkg::osw_variant_type'(
        bus.wdata[osw_pkg::CFG_VARIANT_LSB +: 2]);
      ext_clk <= bus.wdata[osw_pkg::CFG_EXT_CLK_BIT];
    end
  end

  // Wake target: subactive instead of straight to active
  always_ff @(posedge clk) begin
    if (!resetn) begin
      sub_target <= 1'b0;
    end else if (wr_mode) begin
      sub_target <= bus.wdata[osw_pkg::MODE_SUB_TARGET_BIT];
    end
  end

  // Mode requests are single-cycle pulses taken from the write itself
  assign sleep_req = wr_mode && bus.wdata[osw_pkg::MODE_SLEEP_BIT];
  assign active_req = wr_mode && bus.wdata[osw_pkg::MODE_ACTIVE_BIT];

  // ----------------------------------------------------------------------
  // Wake pin synchroniser
  // ----------------------------------------------------------------------
  // Three stages; only the agreeing second and third stages are judged
  // The pin is not tied to clk, so the first stage may go metastable;
  // nothing but the second stage ever reads it
  always_ff @(posedge clk) begin
    if (!resetn) begin
      wake_s1 <= 1'b0;
      wake_s2 <= 1'b0;
      wake_s3 <= 1'b0;
    end else begin
      wake_s1 <= wake_pin;
      wake_s2 <= wake_s1;
      wake_s3 <= wake_s2;
    end
  end

  // Filtered level, updated only when two late stages agree
  always_ff @(posedge clk) begin
    if (!resetn) begin
      wake_level <= 1'b0;
    end else if (wake_s2 == wake_s3) begin
      wake_level <= wake_s3;
    end
  end

  // One-cycle wake pulse; the level resets low like the idle pin, so
  // releasing reset never shows a false edge
  assign wake_rise = (wake_s2 == wake_s3) && wake_s3 && !wake_level;

  // ----------------------------------------------------------------------
  // Cycle count lookup
  // ----------------------------------------------------------------------
  // Looked up from the live selection; the counter samples it only at
  // the load edge
  osw_wait_lookup u_lookup (
    .variant(variant),
    .sel(sel),
    .cycles(wait_cycles),
    .ext_code(ext_code)
  );

  // Software misuse: external code chosen while a resonator runs.
  // The block still honours the code; it only reports the hazard.
  assign code_mismatch = ext_code && !ext_clk;

  // ----------------------------------------------------------------------
  // Mode state machine
  // ----------------------------------------------------------------------
  // Count is sampled at wait entry, so later selection writes do not
  // shorten a wait already under way
  always_comb begin
    next_state = state;
    cnt_load = 1'b0;
    case (state)
      osw_pkg::ST_ACTIVE: begin
        if (sleep_req) begin
          next_state = osw_pkg::ST_HALT;
        end
      end
      osw_pkg::ST_HALT: begin
        if (wake_rise && sub_target) begin
          next_state = osw_pkg::ST_SUB;
        end else if (wake_rise) begin
          next_state = osw_pkg::ST_WAIT; // [R1]
          cnt_load = 1'b1;
        end
      end
      osw_pkg::ST_SUB: begin
        if (active_req) begin
          next_state = osw_pkg::ST_WAIT; // [R1]
          cnt_load = 1'b1;
        end else if (sleep_req) begin
          next_state = osw_pkg::ST_HALT;
        end
      end
      // Sleep and active requests are ignored here: the wait always
      // runs to its end before the system clock comes back
      osw_pkg::ST_WAIT: begin
        if (cnt_last) begin
          next_state = osw_pkg::ST_ACTIVE; // [R2]
        end
      end
      default: begin
        next_state = osw_pkg::ST_ACTIVE;
      end
    endcase
  end

  // State register; reset leaves the device running
  always_ff @(posedge clk) begin
    if (!resetn) begin
      state <= osw_pkg::ST_ACTIVE;
    end else begin
      state <= next_state;
    end
  end

  // Counter advances only while waiting
  assign cnt_run = (state == osw_pkg::ST_WAIT);

  // Load takes priority over counting, so a new wait starts clean
  osw_wait_counter u_counter (
    .clk(clk),
    .resetn(resetn),
    .load(cnt_load),
    .load_value(wait_cycles),
    .run(cnt_run),
    .remain(cnt_remain),
    .last(cnt_last)
  );

  // ----------------------------------------------------------------------
  // Clock control outputs
  // ----------------------------------------------------------------------
  // Oscillator runs in active and during the wait; system clock only
  // once the full count has elapsed
  // Both come from next_state so they switch on the same edge as the
  // state register and never lag it by a cycle
  always_ff @(posedge clk) begin
    if (!resetn) begin
      osc_run <= 1'b1;
      sysclk_en <= 1'b1;
    end else begin
      osc_run <= (next_state == osw_pkg::ST_ACTIVE) ||
                 (next_state == osw_pkg::ST_WAIT); // [R2]
      sysclk_en <= (next_state == osw_pkg::ST_ACTIVE); // [R2]
    end
  end

  // State exported straight from its register
  assign mode_state = state;

  // ----------------------------------------------------------------------
  // Register read
  // ----------------------------------------------------------------------
  // Read data stand for exactly the cycle after the read strobe
  // Unmapped offsets read as zero; STATUS and REMAIN ignore writes
  always_ff @(posedge clk) begin
    if (!resetn) begin
      rdata <= 32'h00000000;
    end else if (bus.rd) begin
      case (bus.addr)
        osw_pkg::ADDR_CTRL_ONE: begin
          rdata <= {29'h00000000, sel.wait_sel_bit2, sel.wait_sel_bit1,
                    sel.wait_sel_bit0};
        end
        osw_pkg::ADDR_CTRL_THREE: begin
          rdata <= {31'h00000000, sel.wait_sel_bit3};
        end
        osw_pkg::ADDR_CONFIG: begin
          rdata <= {29'h00000000, ext_clk, variant};
        end
        osw_pkg::ADDR_MODE: begin
          rdata <= {29'h00000000, sub_target, 2'h0};
        end
        osw_pkg::ADDR_STATUS: begin
          rdata <= {26'h0000000, code_mismatch, ext_code, osc_run,
                    sysclk_en, state};
        end
        osw_pkg::ADDR_REMAIN: begin
          rdata <= {14'h0000, cnt_remain};
        end
        default: begin
          rdata <= 32'h00000000; // Unmapped reads return zero
        end
      endcase
    end else begin
      rdata <= 32'h00000000;
    end
  end

endmodule : osw_wait_ctrl

`default_nettype wire

// ===== osw_wait_ctrl_assertions.sv
`default_nettype none

module osw_wait_ctrl_assertions (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Register port
  input wire osw_pkg::osw_bus_type bus,
  input wire logic [31:0] rdata,
  // Wake and clock control
  input wire logic wake_pin,
  input wire logic osc_run,
  input wire logic sysclk_en,
  input wire osw_pkg::osw_state_type mode_state
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);

  // ----------
  // Helper logic
  // ----------
  // Wait length; one spare bit so a runaway count still shows
  logic [18:0] wait_len;
  always_ff @(posedge clk) begin
    if (!resetn) begin
      wait_len <= 19'h00000;
    end else if (mode_state == osw_pkg::ST_WAIT) begin
      wait_len <= wait_len + 19'h00001;
    end else begin
      wait_len <= 19'h00000;
    end
  end

  sequence s_enter_wait;
    mode_state == osw_pkg::ST_WAIT && $past(mode_state) != osw_pkg::ST_WAIT;
  endsequence
  sequence s_leave_wait;
    mode_state == osw_pkg::ST_ACTIVE && $past(mode_state) == osw_pkg::ST_WAIT;
  endsequence

  // ----------
  // Properties
  // ----------
  a_sysclk_only_active: assert property (
    sysclk_en == (mode_state == osw_pkg::ST_ACTIVE))
    else $error("system clock gate disagrees with state");
  a_osc_follows_mode: assert property (
    osc_run == (mode_state inside {osw_pkg::ST_ACTIVE, osw_pkg::ST_WAIT}))
    else $error("oscillator enable disagrees with state");
  a_wait_from_stop: assert property (
    s_enter_wait |-> $past(mode_state) inside
      {osw_pkg::ST_HALT, osw_pkg::ST_SUB})
    else $error("wait entered from a running mode");
  a_wait_start: assert property (
    s_enter_wait |-> !sysclk_en ##1 mode_state == osw_pkg::ST_WAIT)
    else $error("wait shorter than two cycles");
  a_wait_length: assert property (
    s_leave_wait |-> $onehot(wait_len) && wait_len >= 19'h00002 &&
      wait_len <= 19'h20000)
    else $error("wait length not a legal count");
  a_wait_exit: assert property (
    mode_state == osw_pkg::ST_WAIT |=> mode_state inside
      {osw_pkg::ST_WAIT, osw_pkg::ST_ACTIVE})
    else $error("wait left for a mode other than active");
  a_halt_exit: assert property (
    mode_state == osw_pkg::ST_HALT |=> mode_state inside
      {osw_pkg::ST_HALT, osw_pkg::ST_SUB, osw_pkg::ST_WAIT})
    else $error("halt left without the wait");
  a_sub_exit: assert property (
    mode_state == osw_pkg::ST_SUB |=> mode_state inside
      {osw_pkg::ST_SUB, osw_pkg::ST_WAIT})
    else $error("sub mode left without the wait");

  a_wake_before_exit: assert property (
    $past(mode_state) == osw_pkg::ST_HALT &&
      mode_state != osw_pkg::ST_HALT |-> $past(wake_pin, 4))
    else $error("halt left without a wake");

  c_wait_seen: cover property (s_leave_wait);
endmodule : osw_wait_ctrl_assertions

bind osw_wait_ctrl osw_wait_ctrl_assertions u_osw_chk (
  .clk(clk), .resetn(resetn), .bus(bus), .rdata(rdata),
  .wake_pin(wake_pin), .osc_run(osc_run), .sysclk_en(sysclk_en),
  .mode_state(mode_state)
);

`default_nettype wire

// ===== osw_wait_ctrl_test.sv
`default_nettype none

module osw_wait_ctrl_test;
  timeunit 1ns;
  timeprecision 1ps;

  // ----------
  // Signals
  // ----------
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic wake_pin = 1'b0;
  osw_pkg::osw_bus_type bus = '0;
  logic [31:0] rdata;
  logic osc_run;
  logic sysclk_en;
  osw_pkg::osw_state_type mode_state;
  logic [31:0] rd_word;
  int errors = 0;
  int checks_done = 0;
  int cycles = 0;
  int wait_cnt;

  // Cases as {variant, select code, expected wait cycles}
  localparam logic [23:0] CASES [18] = '{
    24'h940002, 24'h980008, 24'h9C0010, 24'h880400, 24'hA00100,
    24'hA40200, 24'hA88000, 24'hB40004, 24'hB80020, 24'hBC0080,
    24'h340002, 24'h180008, 24'h1C0010, 24'h002000, 24'h540100,
    24'h580200, 24'h480400, 24'h5C0010
  };

  always #12.5 clk = ~clk;

  osw_wait_ctrl dut (
    .clk(clk), .resetn(resetn), .bus(bus), .rdata(rdata),
    .wake_pin(wake_pin), .osc_run(osc_run), .sysclk_en(sysclk_en),
    .mode_state(mode_state)
  );

  // ----------
  // Tasks
  // ----------
  task automatic test_done();
    $display("checks %0d, mismatches %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : test_done

  task automatic check32(input logic [31:0] got, input logic [31:0] exp,
                         input string what);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: %s got %h", $time, what, got);
    end
  endtask : check32

  // Gap cycle after each strobe keeps one assignment per time step
  task automatic bus_write(input logic [7:0] a, input logic [31:0] d);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    bus <= '0;
    @(posedge clk);
  endtask : bus_write

  task automatic reg_check(input logic [7:0] a, input logic [31:0] exp,
                           input string what);
    bus <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    bus <= '0;
    @(negedge clk);
    rd_word = rdata;
    @(posedge clk);
    check32(rd_word, exp, what);
  endtask : reg_check

  // Sleep, wake (direct or via sub mode), then time the wait
  task automatic run_wait(input logic [23:0] t, input bit sub);
    int guard;
    int cnt;
    logic [3:0] code;
    logic ext;
    code = t[21:18];
    ext = code[2:0] == 3'h5 && t[23:22] != osw_pkg::VAR_SECOND3;
    bus_write(osw_pkg::ADDR_CTRL_ONE, {29'h0, code[2:0]});
    bus_write(osw_pkg::ADDR_CTRL_THREE, {31'h0, code[3]});
    bus_write(osw_pkg::ADDR_CONFIG, {29'h0, ext, t[23:22]});
    bus_write(osw_pkg::ADDR_MODE, sub ? 32'h5 : 32'h1);
    @(negedge clk);
    check32({29'h0, mode_state, osc_run}, 32'h2, "halt, osc off");
    @(posedge clk);
    wake_pin <= 1'b1;
    if (sub) begin
      for (guard = 0; guard < 8 && mode_state !== osw_pkg::ST_SUB;
           guard++) begin
        @(negedge clk);
      end
      check32({29'h0, mode_state, osc_run}, 32'h4, "sub, osc off");
      @(posedge clk);
      bus <= '{addr: osw_pkg::ADDR_MODE, wdata: 32'h2, wr: 1'b1, rd: 1'b0};
      @(posedge clk);
      bus <= '0;
      @(negedge clk);
    end
    for (guard = 0; guard < 8 && mode_state !== osw_pkg::ST_WAIT;
         guard++) begin
      @(negedge clk);
    end
    check32({30'h0, sysclk_en, osc_run}, 32'h1, "clock held");
    for (cnt = 0; cnt < 200000 && mode_state === osw_pkg::ST_WAIT;
         cnt++) begin
      @(negedge clk);
    end
    check32(cnt, {14'h0, t[17:0]}, "wait");
    check32({30'h0, sysclk_en, osc_run}, 32'h3, "clock on");
    @(posedge clk);
    wake_pin <= 1'b0;
  endtask : run_wait

  // ----------
  // Sequence
  // ----------
  // Hang guard: all cases need about 46000 cycles
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      errors++;
      $display("unexpected at %0t: timeout", $time);
      test_done();
    end
  end

  initial begin
    repeat (3) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    reg_check(osw_pkg::ADDR_CONFIG, 32'h2, "config reset");
    reg_check(osw_pkg::ADDR_CTRL_ONE, 32'h0, "select reset");
    reg_check(osw_pkg::ADDR_STATUS, 32'hC, "status reset");
    reg_check(8'h20, 32'h0, "unmapped read");
    bus_write(8'h20, 32'hFFFFFFFF);
    bus_write(osw_pkg::ADDR_CTRL_ONE, 32'h5);
    reg_check(osw_pkg::ADDR_CTRL_ONE, 32'h5, "select readback");
    reg_check(osw_pkg::ADDR_STATUS, 32'h3C, "ext code no ext clk");
    bus_write(osw_pkg::ADDR_CONFIG, 32'h6);
    reg_check(osw_pkg::ADDR_STATUS, 32'h1C, "ext code, ext clk");
    bus_write(osw_pkg::ADDR_MODE, 32'h6);
    reg_check(osw_pkg::ADDR_MODE, 32'h4, "sub target readback");
    reg_check(osw_pkg::ADDR_STATUS, 32'h1C, "active request ignored");
    $display("test registers done");
    // Wait of 256 cycles; writes during it must not shorten or stop it
    bus_write(osw_pkg::ADDR_CTRL_ONE, 32'h0);
    bus_write(osw_pkg::ADDR_CTRL_THREE, 32'h1);
    reg_check(osw_pkg::ADDR_CTRL_THREE, 32'h1, "top select");
    bus_write(osw_pkg::ADDR_CONFIG, 32'h2);
    bus_write(osw_pkg::ADDR_MODE, 32'h1);
    wake_pin <= 1'b1;
    for (wait_cnt = 0; wait_cnt < 8 && mode_state !== osw_pkg::ST_WAIT;
         wait_cnt++) begin
      @(negedge clk);
    end
    @(posedge clk);
    reg_check(osw_pkg::ADDR_REMAIN, 32'hFF, "remain in wait");
    bus_write(osw_pkg::ADDR_CTRL_ONE, 32'h5);
    bus_write(osw_pkg::ADDR_MODE, 32'h1);
    @(negedge clk);
    for (wait_cnt = 7; wait_cnt < 300 && mode_state === osw_pkg::ST_WAIT;
         wait_cnt++) begin
      @(negedge clk);
    end
    check32(wait_cnt, 32'h100, "wait with writes");
    @(posedge clk);
    wake_pin <= 1'b0;
    reg_check(osw_pkg::ADDR_REMAIN, 32'h0, "remain spent");
    $display("test wait refusals done");
    run_wait(24'h940002, 1'b1);
    $display("test sub wake done");
    // Includes one code (D, first 3-bit variant) whose top bit a 3-bit variant must ignore
    foreach (CASES[i]) begin
      run_wait(CASES[i], 1'b0);
      $display("test wait case %0d done", i);
    end
    test_done();
  end
endmodule : osw_wait_ctrl_test

`default_nettype wire
